// File: src/itcs_interval_timer.sv
// Three interval timers advanced by cycle steals, with APB access
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
module itcs_interval_timer
    import itcs_pkg::*;
#(
    // Tap per timer, 4 bits each, A in the low nibble; 0 is the ninth stage
    parameter logic [11:0] TB_SEL = 12'h420
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic timer_irq_level,
    output logic steal_active
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic bph_reg;
    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] pre_inc;
    logic [PRE_W-1:0] pre_next;
    itcs_trim_t trim_reg;
    itcs_trim_t trim_next;
    logic [PRE_W-1:0] pre_prev_reg;
    logic [2:0] mask_reg;
    logic [2:0] cmd_word_reg;
    logic cmd_pend_reg;
    logic cmd_apply;
    logic [2:0] tick;
    logic [2:0] fc_reg;
    logic [2:0] csr_reg;
    logic [2:0] irq_reg;
    logic [2:0] srv_onehot;
    itcs_state_t state_reg;
    logic [2:0] ph_reg;
    logic [1:0] srv_reg;
    logic [1:0] prio_idx;
    logic poll;
    logic [WORD_W-1:0] ireg_reg;
    logic [WORD_W-1:0] mem_reg [NUM_TIMERS];
    logic wr_acc;
    logic setup;
    logic [2:0] word_hit;
    logic hit;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler; free running so timing survives run, trace and wait
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bph_reg <= 1'b0;
        end else begin
            bph_reg <= ~bph_reg;
        end
    end

    always_comb begin
        pre_inc = pre_reg + PRE_W'(1);
        pre_next = pre_inc;
        trim_next = trim_reg;
        case (trim_reg)
            TR_IDLE: begin
                if (pre_inc[FIRST_TAP]) begin
                    pre_next[3:2] = 2'h3;
                    trim_next = TR_FORCED;
                end
            end
            TR_FORCED: begin
                if (pre_reg[1] && !pre_inc[1]) begin
                    pre_next[3:2] = 2'h0;
                    trim_next = TR_DONE;
                end
            end
            TR_DONE: begin
                // Re-arm only once the ninth stage has dropped
                if (!pre_inc[FIRST_TAP]) begin
                    trim_next = TR_IDLE;
                end
            end
            default: begin
                trim_next = TR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pre_reg <= '0;
            trim_reg <= TR_IDLE;
            pre_prev_reg <= '0;
        end else begin
            pre_prev_reg <= pre_reg;
            if (bph_reg) begin
                pre_reg <= pre_next;
                trim_reg <= trim_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Masks, loaded from the pending command at processor phase 5
    assign cmd_apply = cmd_pend_reg && state_reg == S_CPU && ph_reg == PH_CMD;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask_reg <= MASK_RST;
        end else if (cmd_apply) begin
            mask_reg <= ~cmd_word_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_pend_reg <= 1'b0;
            cmd_word_reg <= '0;
        end else if (wr_acc && paddr == ADDR_CMD) begin
            cmd_pend_reg <= 1'b1;
            cmd_word_reg <= pwdata[2:0];
        end else if (cmd_apply) begin
            cmd_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-timer first-cycle, steal request and interrupt flags
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
            localparam int TAP = FIRST_TAP + int'(TB_SEL[4*gi +: 4]);
            logic clr_x7;
            logic irq_set;
            assign tick[gi] = pre_reg[TAP] && !pre_prev_reg[TAP];
            assign clr_x7 = state_reg == S_X7 && srv_onehot[gi];
            assign irq_set = state_reg == S_X2 && srv_onehot[gi]
                && ireg_reg == '0;

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    fc_reg[gi] <= 1'b0;
                end else if (tick[gi] && !mask_reg[gi]) begin
                    fc_reg[gi] <= 1'b1;
                end else if (clr_x7) begin
                    fc_reg[gi] <= 1'b0;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    csr_reg[gi] <= 1'b0;
                end else if (clr_x7) begin
                    csr_reg[gi] <= 1'b0;
                end else if (fc_reg[gi]) begin
                    csr_reg[gi] <= 1'b1;
                end
            end

            // Hardware set wins over a software clear in the same cycle
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    irq_reg[gi] <= 1'b0;
                end else if (irq_set) begin
                    irq_reg[gi] <= 1'b1;
                end else if (wr_acc && paddr == ADDR_STAT
                    && pwdata[STAT_IRQ_LSB + gi]) begin
                    irq_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign timer_irq_level = |irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Processor clock and steal clock
    assign poll = ph_reg == PH_POLL
        && (state_reg == S_CPU || state_reg == S_XREST);
    assign prio_idx = csr_reg[0] ? 2'h0 : (csr_reg[1] ? 2'h1 : 2'h2);
    assign srv_onehot = 3'h1 << srv_reg;
    assign steal_active = state_reg != S_CPU;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= S_CPU;
            ph_reg <= '0;
            srv_reg <= '0;
        end else begin
            case (state_reg)
                S_CPU, S_XREST: begin
                    if (poll && |csr_reg) begin
                        state_reg <= S_X7;
                        ph_reg <= PH_LAST;
                        srv_reg <= prio_idx;
                    end else if (poll && state_reg == S_XREST) begin
                        state_reg <= S_CPU;
                        ph_reg <= PH_LAST;
                    end else begin
                        ph_reg <= ph_reg + 3'h1;
                    end
                end
                S_X7: begin
                    state_reg <= S_X0;
                end
                S_X0: begin
                    state_reg <= S_X1;
                end
                S_X1: begin
                    state_reg <= S_X1H;
                end
                S_X1H: begin
                    state_reg <= S_X2;
                end
                S_X2: begin
                    state_reg <= S_XREST;
                    ph_reg <= PH_XREST0;
                end
                default: begin
                    state_reg <= S_CPU;
                    ph_reg <= '0;
                end
            endcase
        end
    end

    // I register: load at X1, increment on the held X1, written at X2
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ireg_reg <= '0;
        end else if (state_reg == S_X1) begin
            ireg_reg <= mem_reg[srv_reg];
        end else if (state_reg == S_X1H) begin
            ireg_reg <= ireg_reg + WORD_W'(1);
        end
    end

    // Timer words; the steal write-back beats a bus write in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (state_reg == S_X2 && srv_reg == 2'(i)) begin
                    mem_reg[i] <= ireg_reg;
                end else if (wr_acc && word_hit[i]) begin
                    mem_reg[i] <= pwdata[WORD_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            word_hit[i] = paddr == 8'((LOC_TIMER_A + 8'(i)) << 2);
        end
    end

    assign hit = paddr == ADDR_CMD || paddr == ADDR_STAT || |word_hit;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && hit;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata <= '0;
        end else if (setup && !pwrite) begin
            prdata <= '0;
            if (paddr == ADDR_CMD) begin
                prdata[2:0] <= mask_reg;
            end else if (paddr == ADDR_STAT) begin
                prdata[STAT_FC_LSB +: 3] <= fc_reg;
                prdata[STAT_CSR_LSB +: 3] <= csr_reg;
                prdata[STAT_IRQ_LSB +: 3] <= irq_reg;
                prdata[STAT_BUSY_BIT] <= steal_active;
            end else begin
                for (int i = 0; i < NUM_TIMERS; i++) begin
                    if (word_hit[i]) begin
                        prdata[WORD_W-1:0] <= mem_reg[i];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Steal length is fixed, so every check here has a fixed horizon
    a_presc_steps: assert property (
        bph_reg |=> pre_reg != $past(pre_reg))
        else $error("prescaler did not step");
    a_trim_force: assert property (
        bph_reg && trim_reg == TR_IDLE && pre_inc[FIRST_TAP]
        |=> pre_reg[3:2] == 2'h3)
        else $error("stages three and four not forced");
    a_trim_clear: assert property (
        bph_reg && trim_reg == TR_FORCED && pre_reg[1] && !pre_inc[1]
        |=> pre_reg[3:2] == 2'h0)
        else $error("stages three and four not cleared");
    a_mask_blocks_fc: assert property (
        ((fc_reg & ~$past(fc_reg)) & $past(mask_reg)) == 3'h0)
        else $error("masked timer advanced");
    a_fc_on_tick: assert property (
        |(tick & ~mask_reg)
        |=> (fc_reg & $past(tick & ~mask_reg)) == $past(tick & ~mask_reg))
        else $error("unmasked tick did not set first-cycle flop");
    a_csr_from_fc: assert property (
        fc_reg[0] && !(state_reg == S_X7 && srv_reg == 2'h0) |=> csr_reg[0])
        else $error("first-cycle flop did not request a steal");
    a_fc_hold: assert property (
        fc_reg[0] && !(state_reg == S_X7 && srv_reg == 2'h0) |=> fc_reg[0])
        else $error("first-cycle flop dropped before phase 7");
    a_steal_order: assert property (
        state_reg == S_X7 |=> state_reg == S_X0 ##1 state_reg == S_X1)
        else $error("steal phases out of order");
    a_steal_x1_hold: assert property (
        state_reg == S_X1 |=> state_reg == S_X1H ##1 state_reg == S_X2)
        else $error("steal phase 1 not held");
    a_word_incr: assert property (
        state_reg == S_X1 ##1 state_reg == S_X1H
        |=> ##1 mem_reg[$past(srv_reg, 2)] == $past(ireg_reg, 2) + WORD_W'(1))
        else $error("timer word not incremented");
    a_irq_on_zero: assert property (
        state_reg == S_X2 && ireg_reg == '0 |=> irq_reg[$past(srv_reg)])
        else $error("zero wrap did not request");
    a_irq_only_zero: assert property (
        $rose(irq_reg[0]) |-> $past(state_reg) == S_X2
        && $past(ireg_reg) == '0 && $past(srv_reg) == 2'h0)
        else $error("interrupt flag set without a zero word");
    a_poll_phase6: assert property (
        poll && |csr_reg |=> state_reg == S_X7 ##3 state_reg == S_X1H)
        else $error("poll did not start steal");
    a_cpu_frozen: assert property (
        state_reg inside {S_X7, S_X0, S_X1, S_X1H}
        |=> ph_reg == $past(ph_reg))
        else $error("processor clock ran during a steal");
    a_fc_clear_x7: assert property (
        state_reg == S_X7 && !tick[srv_reg]
        |=> !fc_reg[$past(srv_reg)] && !csr_reg[$past(srv_reg)])
        else $error("first-cycle flop not cleared at phase 7");
    a_cmd_mask: assert property (
        cmd_apply && !wr_acc |=> mask_reg == ~$past(cmd_word_reg))
        else $error("mask not loaded at phase 5");
    a_cmd_pend_clr: assert property (
        cmd_apply && !(wr_acc && paddr == ADDR_CMD) |=> !cmd_pend_reg)
        else $error("command applied twice");
    a_prio_order: assert property (
        poll && csr_reg[0] |=> srv_reg == 2'h0)
        else $error("timer A not served first");
    a_prio_b_next: assert property (
        poll && !csr_reg[0] && csr_reg[1] |=> srv_reg == 2'h1)
        else $error("timer B not served before C");

    c_steal: cover property (state_reg == S_X2);
    c_wrap: cover property (state_reg == S_X2 && ireg_reg == '0);
    c_two_pending: cover property (poll && csr_reg[0] && csr_reg[1]);
    c_mask_cmd: cover property (cmd_apply);
    c_chain: cover property (poll && state_reg == S_XREST && |csr_reg);

endmodule // itcs_interval_timer

// File: shared/itcs_pkg.sv
// Constants and types shared by the interval timer block
//
// How it works
// - Each timer uses one fixed time base chosen at build time.
// - An 18-stage binary prescaler divides the oscillator to make time bases.
// - Prescaler advances on every B-phase pulse, whether or not timers run.
// - Ninth stage is the first tap; stages nine to eighteen double periods.
// - Ninth stage forces stages three, four on; cleared at next stage-two fall.
// - An enabled timer adds one to its word per completed period.
// - The timer word is 16 bits and wraps modulo 65,536.
// - Increment to zero sets that timer's interrupt flag; one shared level.
// - After wrapping, a timer keeps counting without program help.
// - Timers keep counting in run, trace and wait states.
// - Each timer has a mask flop, set by reset; a set mask stops it.
// - Control command strobe falls at processor phase 5, updating all masks.
// - Command bit 0,1,2 control masks A,B,C; one enables, zero masks.
// - First-cycle flop set by its tap only while its mask is off.
// - First-cycle flop clears at steal phase 7 or at reset.
// - A set first-cycle flop enables its steal request and interrupt flag.
// - Steal reads the word into the I register, increments, writes back.
// - Interrupt flag sets only if incremented I register is zero.
// - Timer words sit at storage locations 4, 5 and 6.
// - Timer steal holds steal phase 1 one extra time: X7,X0,X1,X1,X2.
// - Requests are polled at phase 6; a hit stops cpu and starts steal clock.
package itcs_pkg;

    localparam int PRE_W = 18;
    localparam int FIRST_TAP = 8;
    localparam int NUM_TIMERS = 3;
    localparam int WORD_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] LOC_TIMER_A = 8'h04;
    localparam int STAT_FC_LSB = 0;
    localparam int STAT_CSR_LSB = 4;
    localparam int STAT_IRQ_LSB = 8;
    localparam int STAT_BUSY_BIT = 12;
    localparam logic [2:0] MASK_RST = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Clock phases
    localparam logic [2:0] PH_CMD = 3'h5;
    localparam logic [2:0] PH_POLL = 3'h6;
    localparam logic [2:0] PH_LAST = 3'h7;
    localparam logic [2:0] PH_XREST0 = 3'h3;

    typedef enum logic [2:0] {
        S_CPU = 3'h0,
        S_X7 = 3'h1,
        S_X0 = 3'h3,
        S_X1 = 3'h2,
        S_X1H = 3'h6,
        S_X2 = 3'h7,
        S_XREST = 3'h5
    } itcs_state_t;

    typedef enum logic [1:0] {
        TR_IDLE = 2'h0,
        TR_FORCED = 2'h1,
        TR_DONE = 2'h3
    } itcs_trim_t;

endpackage

// File: testbench/itcs_apb_host.sv
// APB host model standing in for the processor side of the timer block
`timescale 1ns/10ps
module itcs_apb_host
    import itcs_pkg::*;
(
    input wire logic clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Released lines show inverted values so stale data cannot pass
    task automatic xfer(input logic wr, input logic [7:0] addr,
            input logic [31:0] data, output logic [31:0] rdata,
            output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~data;
    endtask

    // Bit n high lets timer n run, low masks it
    task automatic command(input logic [2:0] run_en, input logic [28:0] junk);
        logic [31:0] q;
        logic e;
        xfer(1'b1, ADDR_CMD, {junk, run_en}, q, e);
    endtask
endmodule // itcs_apb_host

// File: testbench/interval_timer_cycle_steal_tb.sv
// Self-checking bench for the interval timer block
`timescale 1ns/10ps
module interval_timer_cycle_steal_tb
    import itcs_pkg::*;
();
    // Clocks per ninth-stage interval once the trim shortens it
    localparam int PER_A = 1000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, steal;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, lfsr, wc;
    logic e;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int run = 0;
    int steals = 0;
    int s0, n, a, b;

    always #2.5 clk = ~clk;

    itcs_apb_host u_host (.clk(clk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    itcs_interval_timer u_dut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_irq_level(irq), .steal_active(steal));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] word_addr(input int t);
        return {LOC_TIMER_A[5:0], 2'b00} + 8'(t * 4);
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Every steal must last the full stretched sequence
    always @(posedge clk) begin
        cyc++;
        if (resetn === 1'b1 && steal === 1'b1) begin
            run++;
        end else if (run != 0) begin
            check("steal_len", run, 9);
            steals++;
            run = 0;
        end
        if (cyc == 40000) begin
            err_total++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        lfsr = 32'h346d;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        u_host.xfer(1'b0, ADDR_CMD, 32'h0, q, e);
        check("mask_rst", q, {29'h0, MASK_RST});
        u_host.xfer(1'b0, ADDR_STAT, 32'h0, q, e);
        check("stat_rst", q, 32'h0);
        for (int i = 0; i < 3; i++) begin
            u_host.xfer(1'b0, word_addr(i), 32'h0, q, e);
            check("word_rst", q, 32'h0);
        end
        // Every command code, random junk above the mask bits
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_step(lfsr);
            u_host.command(3'(i), lfsr[31:3]);
            repeat (40) @(posedge clk);
            u_host.xfer(1'b0, ADDR_CMD, lfsr, q, e);
            check("mask", q, {29'h0, ~3'(i)});
        end
        lfsr = lfsr_step(lfsr);
        u_host.xfer(1'b1, 8'h20 | (lfsr[7:0] & 8'hfc), lfsr, q, e);
        check("unmapped_wr", e, 1);
        u_host.xfer(1'b0, 8'h20 | (lfsr[7:0] & 8'hfc), lfsr, q, e);
        check("unmapped_rd", q, 32'h0);
        check("unmapped_err", e, 1);
        u_host.command(3'h0, 29'h0);
        repeat (60) @(posedge clk);
        lfsr = lfsr_step(lfsr);
        wc = {16'h0, lfsr[15:0]};
        u_host.xfer(1'b1, word_addr(2), lfsr, q, e);
        u_host.xfer(1'b0, word_addr(2), 32'h0, q, e);
        check("word_width", q, wc);
        // Two timers on different taps, C left masked
        u_host.xfer(1'b1, word_addr(0), 32'h0, q, e);
        u_host.xfer(1'b1, word_addr(1), 32'h0, q, e);
        s0 = steals;
        u_host.command(3'b011, 29'h0);
        repeat (8 * PER_A + 200) @(posedge clk);
        u_host.command(3'h0, 29'h0);
        repeat (60) @(posedge clk);
        u_host.xfer(1'b0, word_addr(0), 32'h0, q, e);
        a = int'(q);
        check("rate_a", a >= 7 && a <= 9, 1);
        u_host.xfer(1'b0, word_addr(1), 32'h0, q, e);
        b = int'(q);
        check("rate_b", b >= 2 && b <= 3, 1);
        u_host.xfer(1'b0, word_addr(2), 32'h0, q, e);
        check("masked_c", q, wc);
        check("steal_count", steals - s0, a + b);
        repeat (2 * PER_A + 500) @(posedge clk);
        u_host.xfer(1'b0, word_addr(0), 32'h0, q, e);
        check("stopped_a", q, 32'(a));
        // Wrap from near full range
        u_host.xfer(1'b1, word_addr(0), 32'h0000_fffe, q, e);
        s0 = steals;
        u_host.command(3'b001, 29'h0);
        n = 0;
        while (irq !== 1'b1 && n < 3 * PER_A) begin
            @(posedge clk);
            n++;
        end
        check("irq_rise", irq, 1);
        check("irq_only_zero", steals - s0, 1);
        u_host.xfer(1'b0, word_addr(0), 32'h0, q, e);
        check("wrap_zero", q, 32'h0);
        u_host.xfer(1'b0, ADDR_STAT, 32'h0, q, e);
        check("irq_flag", q[10:8], 3'b001);
        u_host.xfer(1'b1, ADDR_STAT, 32'h0000_0100, q, e);
        @(posedge clk);
        check("irq_clear", irq, 0);
        repeat (PER_A + 200) @(posedge clk);
        u_host.xfer(1'b0, word_addr(0), 32'h0, q, e);
        check("after_wrap", q >= 1 && q <= 2, 1);
        stop_test();
    end
endmodule // interval_timer_cycle_steal_tb
